// [media_surface_regs.vh]
/*
  constants for the media surface address generator: tile mode codes,
  element size codes, compression type codes, tile constants and shifts.
  assumes it is included once per file by its bare name.
*/
`ifndef MEDIA_SURFACE_REGS_VH
`define MEDIA_SURFACE_REGS_VH

// tile mode codes
`define TILE_LINEAR 3'h0
`define TILE_HORIZ 3'h1
`define TILE_LEGACY_VERT 3'h2
`define TILE_STD_4KB 3'h3
`define TILE_STD_64KB 3'h4

// element size codes
`define BPE_8 3'h0
`define BPE_16 3'h1
`define BPE_32 3'h2
`define BPE_64 3'h3
`define BPE_128 3'h4

// element size in bytes, used for edge replication
`define BYTES_8 5'h01
`define BYTES_16 5'h02
`define BYTES_32 5'h04
`define BYTES_64 5'h08
`define BYTES_128 5'h10

// surface type code of a two-dimensional surface
`define SURF_TYPE_2D 3'h1

// compression types selected by format
`define CMP_NONE 3'h0
`define CMP_Y8 3'h1
`define CMP_UV8 3'h2
`define CMP_Y16 3'h3
`define CMP_YUV422 3'h4

// surface format codes that compress
`define FMT_R8G8_UNORM 9'h106
`define FMT_R8G8_UINT 9'h109
`define FMT_R16_UNORM 9'h10a
`define FMT_R16_UINT 9'h10d
`define FMT_A16_UNORM 9'h113
`define FMT_R8_UNORM 9'h140
`define FMT_R8_UINT 9'h143
`define FMT_A8_UNORM 9'h144
`define FMT_YCRCB_NORMAL 9'h182
`define FMT_YCRCB_SWAPUVY 9'h183
`define FMT_YCRCB_SWAPUV 9'h18f
`define FMT_YCRCB_SWAPY 9'h190

// row and column tile constants per mode
`define ROW_C_LINEAR 4'h0
`define COL_C_LINEAR 4'h0
`define ROW_C_HORIZ 4'h3
`define COL_C_HORIZ 4'h9
`define ROW_C_LEGACY 4'h5
`define COL_C_LEGACY 4'h7
`define ROW_C_64KB_WIDE 4'h6
`define COL_C_64KB_WIDE 4'ha
`define ROW_C_4KB_WIDE 4'h4
`define COL_C_4KB_WIDE 4'h8
`define ROW_C_64KB_MID 4'h7
`define COL_C_64KB_MID 4'h9
`define ROW_C_4KB_MID 4'h5
`define COL_C_4KB_MID 4'h7
`define ROW_C_64KB_BYTE 4'h8
`define COL_C_64KB_BYTE 4'h8
`define ROW_C_4KB_BYTE 4'h6
`define COL_C_4KB_BYTE 4'h6

// placement of the tile index in the offset
`define SHIFT_NONE 5'h00
`define SHIFT_4KB 5'h0c
`define SHIFT_64KB 5'h10

// dword scaling of x and tag granule of compression metadata
`define DWORD_SHIFT 2
`define TAG_GRANULE_SHIFT 8

`endif

// [coord_clamp_uv.v]
/*
  clamps a signed block coordinate into the surface and forms the byte
  column and row coordinates. combinational; assumes width and height
  are at least one.
*/
`timescale 1ns/1ps
`include "media_surface_regs.vh"

module coord_clamp_uv #(
  parameter COORD_W = 16,
  parameter DIM_W = 14
) (
  // request coordinate
  input wire signed [COORD_W-1:0] x_i,
  input wire signed [COORD_W-1:0] y_i,
  // surface geometry
  input wire [DIM_W-1:0] width_i,
  input wire [DIM_W-1:0] height_i,
  input wire [DIM_W-1:0] x_offset_i,
  input wire [DIM_W-1:0] y_offset_i,
  input wire [DIM_W-1:0] line_stride_i,
  input wire [DIM_W-1:0] line_stride_offset_i,
  // results
  output reg [DIM_W-1:0] u_o,
  output reg [DIM_W-1:0] v_o,
  output reg oob_o
);

  reg [DIM_W-1:0] cx;
  reg [DIM_W-1:0] cy;
  reg x_out;
  reg y_out;
  reg [2*DIM_W-1:0] v_wide;
  reg [DIM_W+1:0] u_wide;

  always @* begin
    // edge pixels are replicated by pinning to the first or last row or column
    x_out = 1'b1;
    if (x_i[COORD_W-1]) begin
      cx = {DIM_W{1'b0}}; // RULE1
    end else if ($unsigned(x_i) >= {{(COORD_W-DIM_W){1'b0}}, width_i}) begin
      cx = width_i - 1'b1; // RULE1
    end else begin
      cx = x_i[DIM_W-1:0];
      x_out = 1'b0;
    end
    y_out = 1'b1;
    if (y_i[COORD_W-1]) begin
      cy = {DIM_W{1'b0}}; // RULE1
    end else if ($unsigned(y_i) >= {{(COORD_W-DIM_W){1'b0}}, height_i}) begin
      cy = height_i - 1'b1; // RULE1
    end else begin
      cy = y_i[DIM_W-1:0];
      y_out = 1'b0;
    end
    oob_o = x_out | y_out;
    u_wide = {2'b00, x_offset_i} + {cx, {`DWORD_SHIFT{1'b0}}}; // RULE2
    u_o = u_wide[DIM_W-1:0];
    // interlaced fields come from stride and stride offset
    v_wide = {{DIM_W{1'b0}}, y_offset_i} + {{DIM_W{1'b0}}, line_stride_offset_i}
      + line_stride_i * cy; // RULE3
    v_o = v_wide[DIM_W-1:0];
  end

endmodule

// [tile_offset_swizzle.v]
/*
  maps byte column u and row v into the surface offset for the linear,
  horizontal, legacy vertical and standard 4kb and 64kb tile layouts.
  combinational; pitch is in bytes.
*/
`timescale 1ns/1ps
`include "media_surface_regs.vh"

module tile_offset_swizzle #(
  parameter ADDR_W = 39
) (
  // coordinates and layout
  input wire [13:0] u_i,
  input wire [13:0] v_i,
  input wire [17:0] pitch_i,
  input wire [2:0] tile_mode_i,
  input wire [2:0] bpe_i,
  // offset
  output reg [ADDR_W-1:0] offset_o
);

  reg [3:0] row_c;
  reg [3:0] col_c;
  reg [4:0] lsh;
  reg [15:0] low;
  reg [13:0] u_hi;
  reg [13:0] v_hi;
  reg [17:0] p_hi;
  reg [32:0] tiles;
  reg [48:0] placed;
  reg wide;
  reg byte_el;

  always @*begin
    wide = (bpe_i == `BPE_64) || (bpe_i == `BPE_128);
    byte_el = (bpe_i == `BPE_8);
    // cache line bits are the same in every vertical layout
    low = {10'h000, v_i[1:0], u_i[3:0]};
    row_c = `ROW_C_LINEAR; // RULE5
    col_c = `COL_C_LINEAR; // RULE5
    lsh = `SHIFT_NONE;
    case (tile_mode_i)
      `TILE_HORIZ: begin
        row_c = `ROW_C_HORIZ; // RULE6
        col_c = `COL_C_HORIZ;
        lsh = `SHIFT_4KB;
        low = {4'h0, v_i[2:0], u_i[8:0]}; // RULE6
      end
      `TILE_LEGACY_VERT: begin
        row_c = `ROW_C_LEGACY; // RULE7
        col_c = `COL_C_LEGACY;
        lsh = `SHIFT_4KB;
        low[11:6] = {u_i[6], u_i[5], u_i[4], v_i[4], v_i[3], v_i[2]}; // RULE7
      end
      `TILE_STD_4KB: begin
        lsh = `SHIFT_4KB;
        if (wide) begin
          row_c = `ROW_C_4KB_WIDE; // RULE8
          col_c = `COL_C_4KB_WIDE;
          low[11:6] = {u_i[7], v_i[3], u_i[6], v_i[2], u_i[5], u_i[4]};
        end else if (byte_el) begin
          row_c = `ROW_C_4KB_BYTE; // RULE10
          col_c = `COL_C_4KB_BYTE;
          low[11:6] = {u_i[5], v_i[5], u_i[4], v_i[4], v_i[3], v_i[2]};
        end else begin
          row_c = `ROW_C_4KB_MID; // RULE9
          col_c = `COL_C_4KB_MID;
          low[11:6] = {u_i[6], v_i[4], u_i[5], v_i[3], u_i[4], v_i[2]};
        end
      end
      `TILE_STD_64KB: begin
        lsh = `SHIFT_64KB;
        if (wide) begin
          row_c = `ROW_C_64KB_WIDE; // RULE8
          col_c = `COL_C_64KB_WIDE;
          low[15:6] = {u_i[9], v_i[5], u_i[8], v_i[4], // RULE8
            u_i[7], v_i[3], u_i[6], v_i[2], u_i[5], u_i[4]};
        end else if (byte_el) begin
          row_c = `ROW_C_64KB_BYTE; // RULE10
          col_c = `COL_C_64KB_BYTE;
          low[15:6] = {u_i[7], v_i[7], u_i[6], v_i[6], // RULE10
            u_i[5], v_i[5], u_i[4], v_i[4], v_i[3], v_i[2]};
        end else begin
          row_c = `ROW_C_64KB_MID; // RULE9
          col_c = `COL_C_64KB_MID;
          low[15:6] = {u_i[8], v_i[6], u_i[7], v_i[5], // RULE9
            u_i[6], v_i[4], u_i[5], v_i[3], u_i[4], v_i[2]};
        end
      end
      default: begin
        low = 16'h0000; // RULE5
      end
    endcase
    u_hi = u_i >> col_c;
    v_hi = v_i >> row_c;
    p_hi = pitch_i >> col_c;
    // tile index, or for linear the byte offset itself
    // product widened first; inside a concatenation it would keep only 18 bits
    tiles = {19'h00000, v_hi} * {15'h0000, p_hi} + {19'h00000, u_hi};
    placed = {16'h0000, tiles} << lsh;
    offset_o = placed[ADDR_W-1:0] | {{(ADDR_W-16){1'b0}}, low};
  end

endmodule

// [media_surface_address_gen.v]
/*
  media surface address generator: clamps block pixel coordinates,
  forms u and v, tiles them into a byte address and marks compressed
  reads and writes for the memory side. assumes surface state is held
  steady while requests flow and that the memory side accepts one
  request per cycle; two cycles from request to address.
*/
// Operation
// RULE1 - clamp x to 0..width-1 and y to 0..height-1 first
// RULE2 - u is surface x offset plus four times clamped x
// RULE3 - v is y offset plus stride offset plus stride times clamped y
// RULE4 - byte address is surface base plus tiled offset
// RULE5 - linear: constants zero, offset u plus v times pitch
// RULE6 - horizontal tiling: row 3, column 9, v2..0 and u8..0 low
// RULE7 - legacy vertical tiling: row 5, column 7, bits u6 u5 u4 v4 v3 v2
// RULE8 - 64/128-bit: 64kb row 6 column 10, 4kb row 4 column 8
// RULE9 - 16/32-bit: 64kb row 7 column 9, 4kb row 5 column 7
// RULE10 - 8-bit: 64kb row 8 column 8, 4kb row 6 column 6
// RULE11 - software aligns tiled surface base to the tile size
// RULE12 - compressed surfaces are decompressed on reads
// RULE13 - compression tags come from the slack between width and pitch
// RULE14 - writes to compressible surfaces store uncompressed blocks
// RULE15 - software selects gpu coherence when compression is on
// RULE16 - software aligns base to 32 bytes, width to dwords
// RULE17 - software makes linear pitch a multiple of 64 bytes
// RULE18 - writes to linear or horizontal tiling are at most 16 rows
// RULE19 - writes and 4:2:2 formats use dword-aligned offset and width
// RULE20 - block offset and width align to the pixel size
// RULE21 - data passes unconverted; only two-dimensional surfaces accepted
// RULE22 - uncompressed surfaces use format only for edge replication
// RULE23 - compressible surfaces also take compression type from format
`timescale 1ns/1ps
`include "media_surface_regs.vh"

module media_surface_address_gen #(
  parameter COORD_W = 16,
  parameter DIM_W = 14,
  parameter ADDR_W = 39,
  parameter DATA_W = 32
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // surface state
  input wire [ADDR_W-1:0] surf_base_i,
  input wire [DIM_W-1:0] surf_width_i,
  input wire [DIM_W-1:0] surf_height_i,
  input wire [17:0] surf_pitch_i,
  input wire [DIM_W-1:0] surf_x_offset_i,
  input wire [DIM_W-1:0] surf_y_offset_i,
  input wire [DIM_W-1:0] line_stride_i,
  input wire [DIM_W-1:0] line_stride_offset_i,
  input wire [2:0] tile_mode_i,
  input wire [2:0] bpe_i,
  input wire [8:0] surf_format_i,
  input wire [2:0] surf_type_i,
  input wire compress_en_i,
  // request from the media message path
  input wire req_valid_i,
  input wire req_write_i,
  input wire signed [COORD_W-1:0] req_x_i,
  input wire signed [COORD_W-1:0] req_y_i,
  input wire [DATA_W-1:0] req_wdata_i,
  // request to memory
  output reg mem_valid_o,
  output reg mem_write_o,
  output reg [ADDR_W-1:0] mem_addr_o,
  output reg [DATA_W-1:0] mem_wdata_o,
  output reg mem_decompress_o,
  output reg mem_store_uncomp_o,
  output reg [2:0] mem_cmp_type_o,
  output reg [ADDR_W-1:0] mem_tag_addr_o,
  output reg [4:0] repl_bytes_o,
  output reg oob_o,
  output reg type_err_o,
  // read data from memory and back to the requester
  input wire mem_rvalid_i,
  input wire [DATA_W-1:0] mem_rdata_i,
  output reg rsp_valid_o,
  output reg [DATA_W-1:0] rsp_data_o
);

  wire [DIM_W-1:0] u_w;
  wire [DIM_W-1:0] v_w;
  wire oob_w;
  wire [ADDR_W-1:0] tile_off_w;

  reg s1_valid_r;
  reg s1_write_r;
  reg s1_oob_r;
  reg [DIM_W-1:0] s1_u_r;
  reg [DIM_W-1:0] s1_v_r;
  reg [DATA_W-1:0] s1_wdata_r;
  reg type_err_nxt;
  reg [2:0] cmp_type_nxt;
  reg [4:0] repl_nxt;
  reg [31:0] row_base;
  reg [ADDR_W-1:0] tag_addr_nxt;
  reg accept;

  coord_clamp_uv #(
    .COORD_W(COORD_W),
    .DIM_W(DIM_W)
  ) u_clamp (
    .x_i(req_x_i),
    .y_i(req_y_i),
    .width_i(surf_width_i),
    .height_i(surf_height_i),
    .x_offset_i(surf_x_offset_i),
    .y_offset_i(surf_y_offset_i),
    .line_stride_i(line_stride_i),
    .line_stride_offset_i(line_stride_offset_i),
    .u_o(u_w),
    .v_o(v_w),
    .oob_o(oob_w)
  );

  tile_offset_swizzle #(
    .ADDR_W(ADDR_W)
  ) u_swizzle (
    .u_i(s1_u_r[13:0]),
    .v_i(s1_v_r[13:0]),
    .pitch_i(surf_pitch_i),
    .tile_mode_i(tile_mode_i),
    .bpe_i(bpe_i),
    .offset_o(tile_off_w)
  );

  always @* begin
    // only two-dimensional surfaces are served; others are dropped
    accept = req_valid_i && (surf_type_i == `SURF_TYPE_2D); // RULE21
    type_err_nxt = req_valid_i && (surf_type_i != `SURF_TYPE_2D); // RULE21
  end

  always @* begin
    // element size decides how edge pixels replicate
    case (bpe_i)
      `BPE_8: repl_nxt = `BYTES_8; // RULE22
      `BPE_16: repl_nxt = `BYTES_16;
      `BPE_32: repl_nxt = `BYTES_32;
      `BPE_64: repl_nxt = `BYTES_64;
      `BPE_128: repl_nxt = `BYTES_128;
      default: repl_nxt = `BYTES_32;
    endcase
  end

  always @* begin
    // unsupported formats fall back to no compression
    cmp_type_nxt = `CMP_NONE;
    if (compress_en_i) begin
      case (surf_format_i)
        `FMT_R8_UNORM, `FMT_R8_UINT, `FMT_A8_UNORM: cmp_type_nxt = `CMP_Y8; // RULE23
        `FMT_R8G8_UNORM, `FMT_R8G8_UINT: cmp_type_nxt = `CMP_UV8; // RULE23
        `FMT_R16_UNORM, `FMT_R16_UINT, `FMT_A16_UNORM: cmp_type_nxt = `CMP_Y16;
        `FMT_YCRCB_NORMAL, `FMT_YCRCB_SWAPUVY, `FMT_YCRCB_SWAPUV,
        `FMT_YCRCB_SWAPY: cmp_type_nxt = `CMP_YUV422;
        default: cmp_type_nxt = `CMP_NONE;
      endcase
    end
  end

  always @* begin
    // tags sit past the last pixel of the row, inside the pitch slack
    row_base = s1_v_r[13:0] * surf_pitch_i;
    tag_addr_nxt = surf_base_i + {{(ADDR_W-32){1'b0}}, row_base} // RULE13
      + {{(ADDR_W-DIM_W-`DWORD_SHIFT){1'b0}}, surf_width_i, {`DWORD_SHIFT{1'b0}}}
      + {{(ADDR_W-DIM_W){1'b0}}, (s1_u_r >> `TAG_GRANULE_SHIFT)};
  end

  // stage one: clamp and u/v
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1_valid_r <= 1'b0;
      s1_write_r <= 1'b0;
      s1_oob_r <= 1'b0;
      s1_u_r <= {DIM_W{1'b0}};
      s1_v_r <= {DIM_W{1'b0}};
      s1_wdata_r <= {DATA_W{1'b0}};
      type_err_o <= 1'b0;
    end else begin
      s1_valid_r <= accept;
      type_err_o <= type_err_nxt;
      if (accept) begin
        s1_write_r <= req_write_i;
        s1_oob_r <= oob_w; // RULE1
        s1_u_r <= u_w; // RULE2
        s1_v_r <= v_w; // RULE3
        s1_wdata_r <= req_wdata_i; // RULE21
      end
    end
  end

  // stage two: address and compression marks
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      mem_valid_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_addr_o <= {ADDR_W{1'b0}};
      mem_wdata_o <= {DATA_W{1'b0}};
      mem_decompress_o <= 1'b0;
      mem_store_uncomp_o <= 1'b0;
      mem_cmp_type_o <= `CMP_NONE;
      mem_tag_addr_o <= {ADDR_W{1'b0}};
      repl_bytes_o <= `BYTES_32;
      oob_o <= 1'b0;
    end else begin
      mem_valid_o <= s1_valid_r;
      if (s1_valid_r) begin
        mem_write_o <= s1_write_r;
        mem_addr_o <= surf_base_i + tile_off_w; // RULE4
        mem_wdata_o <= s1_wdata_r; // RULE21
        // reads of compressible surfaces expand through the tag
        mem_decompress_o <= compress_en_i && !s1_write_r; // RULE12
        // writes never compress, so the tag is reset to plain
        mem_store_uncomp_o <= compress_en_i && s1_write_r; // RULE14
        mem_cmp_type_o <= s1_write_r ? `CMP_NONE : cmp_type_nxt; // RULE23
        mem_tag_addr_o <= compress_en_i ? tag_addr_nxt : {ADDR_W{1'b0}}; // RULE13
        repl_bytes_o <= repl_nxt; // RULE22
        oob_o <= s1_oob_r;
      end
    end
  end

  // read data returns untouched; decompression happens on the memory side
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= {DATA_W{1'b0}};
    end else begin
      rsp_valid_o <= mem_rvalid_i;
      if (mem_rvalid_i) begin
        rsp_data_o <= mem_rdata_i; // RULE21
      end
    end
  end

endmodule

// [media_surface_address_gen_props.sv]
/* assertions on the media surface address generator top ports.
   assumes surface state holds steady from request to address. */
`timescale 1ns/1ps
module media_surface_address_gen_props #(
  parameter COORD_W = 16,
  parameter DIM_W = 14,
  parameter ADDR_W = 39,
  parameter DATA_W = 32
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // surface state
  input wire [ADDR_W-1:0] surf_base_i,
  input wire [DIM_W-1:0] surf_width_i,
  input wire [DIM_W-1:0] surf_height_i,
  input wire [17:0] surf_pitch_i,
  input wire [DIM_W-1:0] surf_x_offset_i,
  input wire [DIM_W-1:0] surf_y_offset_i,
  input wire [DIM_W-1:0] line_stride_i,
  input wire [DIM_W-1:0] line_stride_offset_i,
  input wire [2:0] tile_mode_i,
  input wire [2:0] surf_type_i,
  input wire compress_en_i,
  // request
  input wire req_valid_i,
  input wire req_write_i,
  input wire signed [COORD_W-1:0] req_x_i,
  input wire signed [COORD_W-1:0] req_y_i,
  // memory side
  input wire mem_valid_o,
  input wire mem_write_o,
  input wire [ADDR_W-1:0] mem_addr_o,
  input wire mem_decompress_o,
  input wire mem_store_uncomp_o,
  input wire oob_o,
  input wire type_err_o,
  input wire mem_rvalid_i,
  input wire [DATA_W-1:0] mem_rdata_i,
  input wire rsp_valid_o,
  input wire [DATA_W-1:0] rsp_data_o
);
  // in-bounds linear address only; tiled layouts are left to the bench
  wire oob_c = req_x_i[COORD_W-1] | req_y_i[COORD_W-1] |
    (req_x_i[COORD_W-2:0] >= surf_width_i) | (req_y_i[COORD_W-2:0] >= surf_height_i);
  wire [DIM_W-1:0] u_c = surf_x_offset_i + {req_x_i[DIM_W-3:0], 2'b00};
  wire [DIM_W-1:0] v_c = surf_y_offset_i + line_stride_offset_i + line_stride_i * req_y_i[DIM_W-1:0];
  wire [ADDR_W-1:0] lin_nxt = surf_base_i + u_c + v_c * surf_pitch_i;
  wire ok_nxt = req_valid_i && surf_type_i == 3'h1 && tile_mode_i == 3'h0 && !oob_c;
  reg [ADDR_W-1:0] lin1_r, lin2_r;
  reg ok1_r, ok2_r;
  always @(posedge sys_clk_i) begin
    ok1_r <= rst_i ? 1'b0 : ok_nxt;
    ok2_r <= rst_i ? 1'b0 : ok1_r;
    lin1_r <= lin_nxt;
    lin2_r <= lin1_r;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_take_to_mem: assert property (req_valid_i && surf_type_i == 3'h1 |-> ##2 mem_valid_o)
    else $error("accepted request gave no memory request");
  a_type_refused: assert property (req_valid_i && surf_type_i != 3'h1 |=> type_err_o ##1 !mem_valid_o)
    else $error("non 2d request not refused");
  a_clamp_flag: assert property (mem_valid_o |-> oob_o == $past(oob_c, 2))
    else $error("clamp flag wrong");
  a_linear_addr: assert property (mem_valid_o && ok2_r |-> mem_addr_o == lin2_r)
    else $error("linear address wrong");
  a_write_kind: assert property (mem_valid_o |-> mem_write_o == $past(req_write_i, 2))
    else $error("write flag wrong");
  a_read_decomp: assert property (mem_valid_o |-> mem_decompress_o == (!mem_write_o && $past(compress_en_i, 2)))
    else $error("decompress flag wrong");
  a_write_plain: assert property (mem_valid_o |-> mem_store_uncomp_o == (mem_write_o && $past(compress_en_i, 2)))
    else $error("uncompressed store flag wrong");
  a_rsp_copy: assert property (mem_rvalid_i |=> rsp_valid_o && rsp_data_o == $past(mem_rdata_i))
    else $error("read data not passed back");
  c_oob: cover property (mem_valid_o && oob_o);
  c_decomp: cover property (mem_valid_o && mem_decompress_o);
  c_type_err: cover property (type_err_o);
endmodule
bind media_surface_address_gen media_surface_address_gen_props #(.COORD_W(COORD_W),
  .DIM_W(DIM_W), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) props_u (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .surf_base_i(surf_base_i), .surf_width_i(surf_width_i),
  .surf_height_i(surf_height_i), .surf_pitch_i(surf_pitch_i), .surf_x_offset_i(surf_x_offset_i),
  .surf_y_offset_i(surf_y_offset_i), .line_stride_i(line_stride_i),
  .line_stride_offset_i(line_stride_offset_i), .tile_mode_i(tile_mode_i),
  .surf_type_i(surf_type_i), .compress_en_i(compress_en_i), .req_valid_i(req_valid_i),
  .req_write_i(req_write_i), .req_x_i(req_x_i), .req_y_i(req_y_i), .mem_valid_o(mem_valid_o),
  .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o), .mem_decompress_o(mem_decompress_o),
  .mem_store_uncomp_o(mem_store_uncomp_o), .oob_o(oob_o), .type_err_o(type_err_o),
  .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i), .rsp_valid_o(rsp_valid_o),
  .rsp_data_o(rsp_data_o));

// [mem_side_model.sv]
/* memory side model: answers one read at a time lat_i+1 cycles after taking it.
   assumes the bench waits for each answer before the next read. */
`timescale 1ns/1ps
module mem_side_model (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // request from the block
  input wire mem_valid_i,
  input wire mem_write_i,
  input wire mem_decompress_i,
  input wire [3:0] lat_i,
  input wire [31:0] pat_i,
  // read data
  output reg rvalid_o,
  output reg [31:0] rdata_o
);
  reg pend_r;
  reg dec_r;
  reg [3:0] cnt_r;
  always @(posedge clk_i) begin
    rvalid_o <= 1'b0;
    // idle data keeps moving so a stale value never matches
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      pend_r <= 1'b0;
      rdata_o <= 32'h0;
    end else if (mem_valid_i && !mem_write_i) begin
      pend_r <= 1'b1;
      cnt_r <= lat_i;
      dec_r <= mem_decompress_i;
    end else if (pend_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= dec_r ? ~pat_i : pat_i;
    end
  end
endmodule

// [test_media_surface_address_gen.sv]
/* self-checking bench for the media surface address generator.
   assumes the design files and the memory side model are compiled first. */
`timescale 1ns/1ps
`include "media_surface_regs.vh"
module test_media_surface_address_gen;
  reg sys_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [38:0] surf_base_i = 39'h0000010000;
  reg [13:0] surf_width_i = 14'h0010;
  reg [13:0] surf_height_i = 14'h0008;
  reg [17:0] surf_pitch_i = 18'h02000;
  reg [13:0] surf_x_offset_i = 14'h0e04;
  reg [13:0] surf_y_offset_i = 14'h00c2;
  reg [13:0] line_stride_i = 14'h0002;
  reg [13:0] line_stride_offset_i = 14'h0001;
  reg [2:0] tile_mode_i = 3'h0;
  reg [2:0] bpe_i = 3'h0;
  reg [8:0] surf_format_i = 9'h0c0;
  reg [2:0] surf_type_i = 3'h1;
  reg compress_en_i = 1'b0;
  reg req_valid_i = 1'b0;
  reg req_write_i = 1'b0;
  reg signed [15:0] req_x_i = 16'h0000;
  reg signed [15:0] req_y_i = 16'h0000;
  reg [31:0] req_wdata_i = 32'h0;
  reg [3:0] lat = 4'h0;
  reg [31:0] pat = 32'h0;
  wire [38:0] mem_addr_o, mem_tag_addr_o;
  wire [31:0] mem_wdata_o, mem_rdata_i, rsp_data_o;
  wire [4:0] repl_bytes_o;
  wire [2:0] mem_cmp_type_o;
  wire mem_valid_o, mem_write_o, mem_decompress_o, mem_store_uncomp_o, oob_o, type_err_o;
  wire mem_rvalid_i, rsp_valid_o;
  integer n_mismatch = 0;
  integer compares = 0;
  integer m, b, p, eu, ev;
  integer xs [0:2];
  integer ys [0:2];
  reg [38:0] eo;
  reg [8:0] fm [0:3];
  reg [2:0] ct [0:3];

  media_surface_address_gen dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .surf_base_i(surf_base_i), .surf_width_i(surf_width_i), .surf_height_i(surf_height_i),
    .surf_pitch_i(surf_pitch_i), .surf_x_offset_i(surf_x_offset_i),
    .surf_y_offset_i(surf_y_offset_i), .line_stride_i(line_stride_i),
    .line_stride_offset_i(line_stride_offset_i), .tile_mode_i(tile_mode_i), .bpe_i(bpe_i),
    .surf_format_i(surf_format_i), .surf_type_i(surf_type_i), .compress_en_i(compress_en_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_x_i(req_x_i),
    .req_y_i(req_y_i), .req_wdata_i(req_wdata_i), .mem_valid_o(mem_valid_o),
    .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_decompress_o(mem_decompress_o), .mem_store_uncomp_o(mem_store_uncomp_o),
    .mem_cmp_type_o(mem_cmp_type_o), .mem_tag_addr_o(mem_tag_addr_o),
    .repl_bytes_o(repl_bytes_o), .oob_o(oob_o), .type_err_o(type_err_o),
    .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o));

  mem_side_model mem_u (.clk_i(sys_clk_i), .rst_i(rst_i), .mem_valid_i(mem_valid_o),
    .mem_write_i(mem_write_o), .mem_decompress_i(mem_decompress_o), .lat_i(lat),
    .pat_i(pat), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));

  initial forever #4 sys_clk_i = ~sys_clk_i;

  task conclude;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task chk(input [38:0] seen, input [38:0] want);
    begin
      compares = compares + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask

  // entered just after an edge; returns just after the edge that raises mem_valid_o
  task req(input integer x, input integer y, input w);
    begin
      req_x_i = x;
      req_y_i = y;
      req_write_i = w;
      req_wdata_i = {x[15:0], y[15:0]} ^ 32'h3c3c3c3c;
      req_valid_i = 1'b1;
      @(posedge sys_clk_i) #1 req_valid_i = 1'b0;
      @(posedge sys_clk_i) #1;
    end
  endtask

  task wait_rsp(input [31:0] want);
    integer k;
    begin
      for (k = 0; k < 20 && rsp_valid_o !== 1'b1; k = k + 1)
        @(posedge sys_clk_i) #1;
      chk(rsp_valid_o, 1'b1);
      chk(rsp_data_o, want);
    end
  endtask

  // expected offset from clamped coordinates, all bits of every layout
  task calc(input integer x, input integer y);
    integer cx, cy, cu, cv, k;
    begin
      cx = x < 0 ? 0 : (x >= surf_width_i ? surf_width_i - 1 : x);
      cy = y < 0 ? 0 : (y >= surf_height_i ? surf_height_i - 1 : y);
      eu = (surf_x_offset_i + 4 * cx) & 32'h00003fff;
      ev = (surf_y_offset_i + line_stride_offset_i + line_stride_i * cy) & 32'h00003fff;
      k = bpe_i >= 3 ? 0 : (bpe_i >= 1 ? 1 : 2);
      cu = tile_mode_i == 0 ? 0 : tile_mode_i == 1 ? 9 : tile_mode_i == 2 ? 7 :
        tile_mode_i == 4 ? 10 - k : 8 - k;
      cv = tile_mode_i == 0 ? 0 : tile_mode_i == 1 ? 3 : tile_mode_i == 2 ? 5 :
        tile_mode_i == 4 ? 6 + k : 4 + k;
      eo = (eu >> cu) + (ev >> cv) * (surf_pitch_i >> cu);
      eo = eo << (tile_mode_i == 0 ? 0 : tile_mode_i == 4 ? 16 : 12);
      if (tile_mode_i == 1)
        eo = eo | {ev[2:0], eu[8:0]};
      if (tile_mode_i == 2)
        eo = eo | {eu[6:4], ev[4:0], eu[3:0]};
      if (tile_mode_i == 4)
        eo = eo | {eu[cu-1], ev[cv-1], eu[cu-2], ev[cv-2], 12'h000};
      if (tile_mode_i == 3 || tile_mode_i == 4)
        eo = eo | {k == 0 ? {eu[7], ev[3], eu[6], ev[2], eu[5], eu[4]} :
          k == 1 ? {eu[6], ev[4], eu[5], ev[3], eu[4], ev[2]} :
          {eu[5], ev[5], eu[4], ev[4], ev[3], ev[2]}, ev[1:0], eu[3:0]};
    end
  endtask

  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end

  initial begin
    xs[0] = 3; ys[0] = 5; xs[1] = -2; ys[1] = 9; xs[2] = 20; ys[2] = -1;
    fm[0] = 9'h140; ct[0] = `CMP_Y8; fm[1] = 9'h10a; ct[1] = `CMP_Y16;
    fm[2] = 9'h106; ct[2] = `CMP_UV8; fm[3] = 9'h0c0; ct[3] = `CMP_NONE;
    repeat (4) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    @(posedge sys_clk_i) #1;
    // every layout and element size, in and out of bounds, slow and prompt memory
    for (m = 0; m < 5; m = m + 1)
      for (b = 0; b < 5; b = b + 1) begin
        tile_mode_i = m;
        bpe_i = b;
        lat = (m + b) % 2 ? 4'h6 : 4'h0;
        for (p = 0; p < 3; p = p + 1) begin
          pat = 32'ha5000000 | (m << 8) | (b << 4) | p;
          calc(xs[p], ys[p]);
          req(xs[p], ys[p], 1'b0);
          chk(mem_valid_o, 1'b1);
          chk(oob_o, p != 0);
          chk(repl_bytes_o, 5'h01 << b);
          case (m)
            0: chk(mem_addr_o, surf_base_i + eo);
            1: chk(mem_addr_o, surf_base_i + eo);
            2: chk(mem_addr_o, surf_base_i + eo);
            default: chk(mem_addr_o, surf_base_i + eo);
          endcase
          wait_rsp(pat);
        end
      end
    // compressed reads decompress, writes store plain
    compress_en_i = 1'b1;
    tile_mode_i = 3'h0;
    for (p = 0; p < 4; p = p + 1) begin
      surf_format_i = fm[p];
      pat = 32'h5a00c300 + p;
      calc(3, 5);
      req(3, 5, 1'b0);
      chk(mem_decompress_o, 1'b1);
      chk(mem_cmp_type_o, ct[p]);
      chk(mem_tag_addr_o, surf_base_i + ev * surf_pitch_i + 4 * surf_width_i + (eu >> 8));
      wait_rsp(~pat);
      req(3, 5, 1'b1);
      chk(mem_store_uncomp_o, 1'b1);
      chk(mem_decompress_o, 1'b0);
      chk(mem_wdata_o, 32'h3c3f3c39);
    end
    // a non two-dimensional surface is refused
    surf_type_i = 3'h2;
    req_valid_i = 1'b1;
    @(posedge sys_clk_i) #1 req_valid_i = 1'b0;
    chk(type_err_o, 1'b1);
    @(posedge sys_clk_i) #1;
    @(posedge sys_clk_i) #1;
    chk(mem_valid_o, 1'b0);
    conclude;
  end
endmodule
